//--- shared/gpro_pkg.sv
/*
 * shared constants for the graphics port request ordering block.
 * assumes requests arrive already decoded from the request port, one per cycle.
 */
package gpro_pkg;
    // request command codes on the request port
    localparam logic [2:0] CMD_LP_READ = 3'h0;
    localparam logic [2:0] CMD_LP_WRITE = 3'h1;
    localparam logic [2:0] CMD_HP_READ = 3'h2;
    localparam logic [2:0] CMD_HP_WRITE = 3'h3;
    localparam logic [2:0] CMD_FLUSH = 3'h4;
    localparam logic [2:0] CMD_FENCE = 3'h5;
    localparam logic [2:0] CMD_BUS_READ = 3'h6;
    localparam logic [2:0] CMD_BUS_WRITE = 3'h7;
    // memory operation kinds issued to the memory side
    localparam logic [1:0] MEM_READ = 2'h0;
    localparam logic [1:0] MEM_WRITE = 2'h1;
    localparam logic [1:0] MEM_FLUSH = 2'h2;
    // stream selectors
    localparam logic [1:0] STR_LP = 2'h0;
    localparam logic [1:0] STR_HP = 2'h1;
    localparam logic [1:0] STR_BUS = 2'h2;
    // defaults
    localparam int QUEUE_DEPTH = 8;
    localparam int ADDR_WIDTH = 32;
    localparam int TAG_WIDTH = 4;
    localparam logic [63:0] FLUSH_REPLY_DATA = 64'h0;
    // high-priority latency window, in ns, and its count of 40 ns cycles
    localparam int HP_WINDOW_NS = 2000;
    localparam int CLOCK_NS = 40;
    localparam int HP_WINDOW_CYCLES = (HP_WINDOW_NS / CLOCK_NS < 1) ? 1 : HP_WINDOW_NS / CLOCK_NS;
endpackage

//--- verilog/gpro_queue.sv
/*
 * in-order request queue of flip-flops for one ordering stream.
 * assumes push and pop on the same clock; a push when full is dropped by the queue itself.
 */
`timescale 1ns/1ns
module gpro_queue #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 8
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_push,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_pop,
    output logic [WIDTH-1:0] o_head,
    output logic o_empty,
    output logic o_full,
    output logic [$clog2(DEPTH+1)-1:0] o_count
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wr_index;
    logic [AW-1:0] rd_index;
    logic do_push;
    logic do_pop;

    // =====================================================
    // pointer step with wrap
    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign do_push = i_push && !o_full;
    assign do_pop = i_pop && !o_empty;
    assign o_head = store[rd_index];
    assign o_empty = (o_count == '0);
    assign o_full = (o_count == ($clog2(DEPTH+1))'(DEPTH));

    // storage written at the tail
    always_ff @(posedge i_clock) begin
        if (do_push) begin
            store[wr_index] <= i_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_index <= '0;
            rd_index <= '0;
            o_count <= '0;
        end else begin
            if (do_push) begin
                wr_index <= step(wr_index);
            end
            if (do_pop) begin
                rd_index <= step(rd_index);
            end
            if (do_push && !do_pop) begin
                o_count <= o_count + 1'b1;
            end else if (do_pop && !do_push) begin
                o_count <= o_count - 1'b1;
            end
        end
    end
endmodule

//--- verilog/gpro_ordering.sv
/*
 * request ordering core: sorts decoded requests into stream queues and issues
 * them to memory under the ordering rules, returning tagged read replies in order.
 * assumes the memory side answers reads in issue order and takes one op when ready.
 */
`timescale 1ns/1ns
module gpro_ordering #(
    parameter int DEPTH = gpro_pkg::QUEUE_DEPTH,
    parameter int AW = gpro_pkg::ADDR_WIDTH
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_req_valid,
    input wire logic [2:0] i_req_cmd,
    input wire logic [AW-1:0] i_req_addr,
    input wire logic [63:0] i_req_wdata,
    output logic o_req_ready,
    output logic o_mem_valid,
    output logic [1:0] o_mem_op,
    output logic [1:0] o_mem_stream,
    output logic [AW-1:0] o_mem_addr,
    output logic [63:0] o_mem_wdata,
    input wire logic i_mem_ready,
    input wire logic i_mem_rvalid,
    input wire logic [63:0] i_mem_rdata,
    input wire logic i_mem_flush_done,
    output logic o_rsp_valid,
    output logic o_rsp_high_priority_stream,
    output logic o_rsp_flush,
    output logic [63:0] o_rsp_data,
    output logic o_hp_window_late
);
    // entry: fence-before flag, is-flush, is-write, address, write data
    localparam int EW = 3 + AW + 64;
    localparam int CW = $clog2(DEPTH + 1);
    typedef enum logic [1:0] {
        GPRO_IDLE = 2'b00,
        GPRO_WAIT_FLUSH = 2'b01,
        GPRO_WAIT_READS = 2'b10
    } gpro_state_t;

    logic [EW-1:0] lp_head, hpr_head, hpw_head, bus_head;
    logic lp_empty, hpr_empty, hpw_empty, bus_empty;
    logic lp_full, hpr_full, hpw_full, bus_full;
    logic [CW-1:0] lp_count, hpr_count, hpw_count, bus_count;
    logic lp_push, hpr_push, hpw_push, bus_push;
    logic lp_pop, hpr_pop, hpw_pop, bus_pop;
    logic [EW-1:0] new_entry;
    logic fence_pending;
    gpro_state_t state;
    // ledger of reads in memory: bit 1 = high-priority, bit 0 = bus-protocol read
    logic [1:0] ledger [4*DEPTH];
    logic [$clog2(4*DEPTH)-1:0] led_wr, led_rd;
    logic [$clog2(4*DEPTH+1)-1:0] led_count;
    logic [CW-1:0] lp_reads_out;
    logic [15:0] hpw_age;
    logic issue;
    logic lp_read_issue, bus_read_issue, lp_read_back;
    logic [1:0] next_src;

    // =====================================================
    // request intake
    // entry field helpers
    function automatic logic is_write(input logic [EW-1:0] e);
        is_write = e[AW+64];
    endfunction
    function automatic logic is_flush(input logic [EW-1:0] e);
        is_flush = e[AW+65];
    endfunction
    function automatic logic fenced(input logic [EW-1:0] e);
        fenced = e[AW+66];
    endfunction

    always_comb begin
        new_entry = {fence_pending, i_req_cmd == gpro_pkg::CMD_FLUSH,
            i_req_cmd == gpro_pkg::CMD_LP_WRITE || i_req_cmd == gpro_pkg::CMD_HP_WRITE
            || i_req_cmd == gpro_pkg::CMD_BUS_WRITE, i_req_addr, i_req_wdata};
    end

    // one lp queue for reads, writes and flushes keeps type order; flush takes a slot
    assign lp_push = i_req_valid && o_req_ready && (i_req_cmd == gpro_pkg::CMD_LP_READ
        || i_req_cmd == gpro_pkg::CMD_LP_WRITE || i_req_cmd == gpro_pkg::CMD_FLUSH);
    assign hpr_push = i_req_valid && o_req_ready && i_req_cmd == gpro_pkg::CMD_HP_READ;
    assign hpw_push = i_req_valid && o_req_ready && i_req_cmd == gpro_pkg::CMD_HP_WRITE;
    assign bus_push = i_req_valid && o_req_ready && (i_req_cmd == gpro_pkg::CMD_BUS_READ
        || i_req_cmd == gpro_pkg::CMD_BUS_WRITE);

    // ready only when the target queue has room; a fence needs no room
    always_comb begin
        case (i_req_cmd)
            gpro_pkg::CMD_LP_READ, gpro_pkg::CMD_LP_WRITE, gpro_pkg::CMD_FLUSH: begin
                // a flush awaiting its reply still holds one slot
                o_req_ready = !lp_full && !(state == GPRO_WAIT_FLUSH
                    && lp_count == CW'(DEPTH - 1));
            end
            gpro_pkg::CMD_HP_READ: begin
                o_req_ready = !hpr_full;
            end
            gpro_pkg::CMD_HP_WRITE: begin
                o_req_ready = !hpw_full;
            end
            gpro_pkg::CMD_FENCE: begin
                o_req_ready = 1'b1;
            end
            default: begin
                o_req_ready = !bus_full;
            end
        endcase
    end

    // a fence marks the next lp entry; fences in a row collapse into one mark
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            fence_pending <= 1'b0;
        end else if (i_req_valid && i_req_cmd == gpro_pkg::CMD_FENCE) begin
            fence_pending <= 1'b1;
        end else if (lp_push) begin
            fence_pending <= 1'b0;
        end
    end

    gpro_queue #(.WIDTH(EW), .DEPTH(DEPTH)) u_lp (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_push(lp_push), .i_data(new_entry),
        .i_pop(lp_pop), .o_head(lp_head), .o_empty(lp_empty), .o_full(lp_full),
        .o_count(lp_count));
    gpro_queue #(.WIDTH(EW), .DEPTH(DEPTH)) u_hpr (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_push(hpr_push), .i_data(new_entry),
        .i_pop(hpr_pop), .o_head(hpr_head), .o_empty(hpr_empty), .o_full(hpr_full),
        .o_count(hpr_count));
    gpro_queue #(.WIDTH(EW), .DEPTH(DEPTH)) u_hpw (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_push(hpw_push), .i_data(new_entry),
        .i_pop(hpw_pop), .o_head(hpw_head), .o_empty(hpw_empty), .o_full(hpw_full),
        .o_count(hpw_count));
    gpro_queue #(.WIDTH(EW), .DEPTH(DEPTH)) u_bus (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_push(bus_push), .i_data(new_entry),
        .i_pop(bus_pop), .o_head(bus_head), .o_empty(bus_empty), .o_full(bus_full),
        .o_count(bus_count));

    // =====================================================
    // issue selection
    // the lp queue is strictly in order, so reads push earlier writes and a later
    // write never passes a read; this is stricter than needed but always legal
    always_comb begin
        next_src = 2'h3;
        if (!hpw_empty) begin
            next_src = gpro_pkg::STR_HP;
        end else if (!hpr_empty) begin
            next_src = 2'h3 - 2'h0; // marker for hp read, resolved below
        end else if (!lp_empty && !(fenced(lp_head) && lp_reads_out != '0)
            && !(is_flush(lp_head) && lp_reads_out != '0)) begin
            next_src = gpro_pkg::STR_LP;
        end else if (!bus_empty) begin
            next_src = gpro_pkg::STR_BUS;
        end
        if (next_src == 2'h3 && hpr_empty) begin
            next_src = 2'h3;
        end
    end

    // a pending flush only stalls the lp and bus streams; hp keeps issuing
    assign issue = (state == GPRO_IDLE || !hpw_empty || !hpr_empty)
        && (!o_mem_valid || i_mem_ready)
        && (next_src != 2'h3 || !hpr_empty) && (led_count < ($bits(led_count))'(4*DEPTH - 1));
    // hp write first, then hp read (3 with reads waiting), lp, bus; lets reads wait
    assign hpw_pop = issue && next_src == gpro_pkg::STR_HP;
    assign hpr_pop = issue && next_src == 2'h3 && !hpr_empty;
    assign lp_pop = issue && next_src == gpro_pkg::STR_LP;
    assign bus_pop = issue && next_src == gpro_pkg::STR_BUS;
    // reads that expect a reply; bus-protocol reads are answered as well
    assign lp_read_issue = lp_pop && !is_write(lp_head) && !is_flush(lp_head);
    assign bus_read_issue = bus_pop && !is_write(bus_head);
    assign lp_read_back = i_mem_rvalid && led_count != '0 && ledger[led_rd] == 2'b00
        && !(state == GPRO_WAIT_FLUSH && i_mem_flush_done);

    // memory request register, stalled by the memory side's ready
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mem_valid <= 1'b0;
            o_mem_op <= gpro_pkg::MEM_READ;
            o_mem_stream <= gpro_pkg::STR_LP;
            o_mem_addr <= '0;
            o_mem_wdata <= 64'h0;
        end else if (issue) begin
            o_mem_valid <= 1'b1;
            if (hpw_pop) begin
                o_mem_op <= gpro_pkg::MEM_WRITE;
                o_mem_stream <= gpro_pkg::STR_HP;
                {o_mem_addr, o_mem_wdata} <= hpw_head[AW+63:0];
            end else if (hpr_pop) begin
                o_mem_op <= gpro_pkg::MEM_READ;
                o_mem_stream <= gpro_pkg::STR_HP;
                {o_mem_addr, o_mem_wdata} <= hpr_head[AW+63:0];
            end else if (lp_pop) begin
                o_mem_op <= is_flush(lp_head) ? gpro_pkg::MEM_FLUSH
                    : (is_write(lp_head) ? gpro_pkg::MEM_WRITE : gpro_pkg::MEM_READ);
                o_mem_stream <= gpro_pkg::STR_LP;
                {o_mem_addr, o_mem_wdata} <= lp_head[AW+63:0];
            end else begin
                o_mem_op <= is_write(bus_head) ? gpro_pkg::MEM_WRITE : gpro_pkg::MEM_READ;
                o_mem_stream <= gpro_pkg::STR_BUS;
                {o_mem_addr, o_mem_wdata} <= bus_head[AW+63:0];
            end
        end else if (i_mem_ready) begin
            o_mem_valid <= 1'b0;
        end
    end

    // =====================================================
    // flush and fence sequencing
    // a flush waits for memory to report the earlier lp writes visible
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= GPRO_IDLE;
        end else begin
            case (state)
                GPRO_IDLE: begin
                    if (lp_pop && is_flush(lp_head)) begin
                        state <= GPRO_WAIT_FLUSH;
                    end
                end
                GPRO_WAIT_FLUSH: begin
                    if (i_mem_flush_done) begin
                        state <= GPRO_IDLE;
                    end
                end
                default: begin
                    state <= GPRO_IDLE;
                end
            endcase
        end
    end

    // =====================================================
    // reply path: ledger of issued reads only, flush replies come from the flush state, replies in issue order
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            led_wr <= '0;
            led_rd <= '0;
            led_count <= '0;
            lp_reads_out <= '0;
            o_rsp_valid <= 1'b0;
            o_rsp_high_priority_stream <= 1'b0;
            o_rsp_flush <= 1'b0;
            o_rsp_data <= 64'h0;
        end else begin
            o_rsp_valid <= 1'b0;
            o_rsp_flush <= 1'b0;
            if (hpr_pop || lp_read_issue || bus_read_issue) begin
                ledger[led_wr] <= {hpr_pop, bus_read_issue};
                led_wr <= led_wr + 1'b1;
            end
            // issue and return in one cycle must leave the count unchanged
            lp_reads_out <= lp_reads_out + CW'(lp_read_issue) - CW'(lp_read_back);
            if (state == GPRO_WAIT_FLUSH && i_mem_flush_done) begin
                o_rsp_valid <= 1'b1;
                o_rsp_flush <= 1'b1;
                o_rsp_high_priority_stream <= 1'b0;
                o_rsp_data <= gpro_pkg::FLUSH_REPLY_DATA;
            end else if (i_mem_rvalid && led_count != '0) begin
                o_rsp_valid <= 1'b1;
                o_rsp_high_priority_stream <= ledger[led_rd][1];
                o_rsp_data <= i_mem_rdata;
                led_rd <= led_rd + 1'b1;
            end
            led_count <= led_count + (($bits(led_count))'(hpr_pop
                || lp_read_issue || bus_read_issue))
                - (($bits(led_count))'(i_mem_rvalid && led_count != '0
                && !(state == GPRO_WAIT_FLUSH && i_mem_flush_done)));
        end
    end

    // hp write age monitor: flags a write left queued past the latency window
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            hpw_age <= 16'h0;
            o_hp_window_late <= 1'b0;
        end else if (hpw_empty || hpw_pop) begin
            hpw_age <= 16'h0;
            o_hp_window_late <= 1'b0;
        end else begin
            hpw_age <= hpw_age + 16'h1;
            o_hp_window_late <= hpw_age >= 16'(gpro_pkg::HP_WINDOW_CYCLES);
        end
    end
endmodule

//--- tb/gpro_ordering_sva.sv
/* assertions on the ports of the request ordering core
   assumes a bind onto gpro_ordering and its one clock domain */
`timescale 1ns/1ns
module gpro_ordering_sva #(
    parameter int AW = 32
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_req_valid,
    input wire logic [2:0] i_req_cmd,
    input wire logic o_req_ready,
    input wire logic o_mem_valid,
    input wire logic [1:0] o_mem_op,
    input wire logic [1:0] o_mem_stream,
    input wire logic [AW-1:0] o_mem_addr,
    input wire logic [63:0] o_mem_wdata,
    input wire logic i_mem_ready,
    input wire logic i_mem_rvalid,
    input wire logic [63:0] i_mem_rdata,
    input wire logic i_mem_flush_done,
    input wire logic o_rsp_valid,
    input wire logic o_rsp_high_priority_stream,
    input wire logic o_rsp_flush,
    input wire logic [63:0] o_rsp_data
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    // ==========================================================
    // reply timing, data and stream tag
    a_read_reply_src: assert property (o_rsp_valid && !o_rsp_flush |-> $past(i_mem_rvalid))
        else $error("read reply without memory data");
    a_reply_data_echo: assert property (
        o_rsp_valid && !o_rsp_flush |-> o_rsp_data == $past(i_mem_rdata))
        else $error("reply data differs from memory data");
    a_read_forward: assert property (i_mem_rvalid |=> o_rsp_valid && !o_rsp_flush)
        else $error("memory data not replied next cycle");
    a_hp_tag_src: assert property (
        o_rsp_valid && o_rsp_high_priority_stream |-> $past(i_mem_rvalid) && !o_rsp_flush)
        else $error("high priority tag on a non read reply");
    a_flush_reply: assert property (
        i_mem_flush_done |=> o_rsp_valid && o_rsp_flush && !o_rsp_high_priority_stream)
        else $error("flush done not acknowledged as low priority");
    a_flush_cause: assert property (o_rsp_flush |-> $past(i_mem_flush_done))
        else $error("flush reply before writes visible");
    // ==========================================================
    // request and memory side
    a_mem_op_hold: assert property (o_mem_valid && !i_mem_ready |=> o_mem_valid &&
        $stable(o_mem_op) && $stable(o_mem_addr) && $stable(o_mem_wdata))
        else $error("memory op changed while stalled");
    a_fence_ready: assert property (
        i_req_valid && i_req_cmd == gpro_pkg::CMD_FENCE |-> o_req_ready)
        else $error("fence refused");
    a_flush_lp_only: assert property (
        o_mem_valid && o_mem_op == gpro_pkg::MEM_FLUSH |-> o_mem_stream == gpro_pkg::STR_LP)
        else $error("flush issued outside low priority stream");
    // ==========================================================
    // main scenarios reached
    c_flush_reply: cover property (o_rsp_valid && o_rsp_flush);
    c_hp_reply: cover property (o_rsp_valid && o_rsp_high_priority_stream);
    c_mem_stall: cover property (o_mem_valid && !i_mem_ready);
    c_queue_full: cover property (i_req_valid && !o_req_ready);
endmodule

//--- tb/gpro_mem_model.sv
/* memory side model facing the ordering core
   assumes one op offered at a time; answers strictly in issue order */
`timescale 1ns/1ns
module gpro_mem_model (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_hold,
    input wire logic i_valid,
    input wire logic [1:0] i_op,
    input wire logic [31:0] i_addr,
    input wire logic [63:0] i_wdata,
    output logic o_ready,
    output logic o_rvalid,
    output logic [63:0] o_rdata,
    output logic o_flush_done
);
    logic [63:0] mem [0:31];
    logic [64:0] pend [$];
    logic [64:0] head;
    initial for (int i = 0; i < 32; i++) mem[i] = 64'h0;
    // ==========================================================
    // accept ops at random, then answer later in issue order
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ready <= 1'b0;
            o_rvalid <= 1'b0;
            o_flush_done <= 1'b0;
            o_rdata <= 64'h0;
            pend.delete();
        end else begin
            o_ready <= !i_hold && ($urandom % 4 != 0);
            if (i_valid && o_ready) begin
                if (i_op == gpro_pkg::MEM_WRITE)
                    mem[i_addr[4:0]] <= i_wdata;
                else
                    pend.push_back({i_op == gpro_pkg::MEM_FLUSH, mem[i_addr[4:0]]});
            end
            o_rvalid <= 1'b0;
            o_flush_done <= 1'b0;
            o_rdata <= ~o_rdata; // data is not held once released
            if (pend.size() > 0 && $urandom % 3 != 0) begin
                head = pend.pop_front();
                o_rvalid <= !head[64];
                o_flush_done <= head[64];
                o_rdata <= head[63:0];
            end
        end
    end
endmodule

//--- tb/graphics_port_request_ordering_tb.sv
/* self-checking bench for the request ordering core
   assumes the package and memory model are compiled first */
`timescale 1ns/1ns
module graphics_port_request_ordering_tb;
    localparam int DEPTH = 4;
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic req_valid = 1'b0;
    logic [2:0] req_cmd = 3'h0;
    logic [31:0] req_addr = 32'h0;
    logic [63:0] req_wdata = 64'h0;
    logic hold = 1'b0;
    logic req_ready, mem_valid, mem_ready, mem_rvalid, flush_done;
    logic rsp_valid, rsp_hp, rsp_flush, hp_late;
    logic [1:0] mem_op, mem_stream;
    logic [31:0] mem_addr;
    logic [63:0] mem_wdata, mem_rdata, rsp_data;
    logic [63:0] shadow [0:31];
    logic [63:0] hp_exp [$];
    logic [64:0] lp_exp [$];
    logic [31:0] hpw_exp [$];
    logic [64:0] e;
    int bad_count = 0;
    int n_checks = 0;
    initial for (int i = 0; i < 32; i++) shadow[i] = 64'h0;
    always #20 i_clock = ~i_clock;
    // ==========================================================
    // design and far side
    gpro_ordering #(.DEPTH(DEPTH), .AW(32)) u_gpro_ordering (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_req_valid(req_valid),
        .i_req_cmd(req_cmd), .i_req_addr(req_addr), .i_req_wdata(req_wdata),
        .o_req_ready(req_ready), .o_mem_valid(mem_valid), .o_mem_op(mem_op),
        .o_mem_stream(mem_stream), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
        .i_mem_ready(mem_ready), .i_mem_rvalid(mem_rvalid), .i_mem_rdata(mem_rdata),
        .i_mem_flush_done(flush_done), .o_rsp_valid(rsp_valid),
        .o_rsp_high_priority_stream(rsp_hp), .o_rsp_flush(rsp_flush),
        .o_rsp_data(rsp_data), .o_hp_window_late(hp_late));
    gpro_mem_model u_gpro_mem_model (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_hold(hold), .i_valid(mem_valid),
        .i_op(mem_op), .i_addr(mem_addr), .i_wdata(mem_wdata), .o_ready(mem_ready),
        .o_rvalid(mem_rvalid), .o_rdata(mem_rdata), .o_flush_done(flush_done));
    // ==========================================================
    // compare, verdict and request tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic timeout();
        bad_count++;
        $display("MISMATCH at %0t: wait ran out", $time);
        end_sim();
    endtask
    task automatic send(input logic [2:0] cmd, input logic [31:0] a, input logic [63:0] d);
        int i;
        req_valid <= 1'b1;
        req_cmd <= cmd;
        req_addr <= a;
        req_wdata <= d;
        for (i = 0; i < 500; i++) begin
            @(negedge i_clock);
            if (req_ready === 1'b1)
                break;
        end
        if (i == 500)
            timeout();
        @(posedge i_clock);
        case (cmd)
            gpro_pkg::CMD_LP_READ, gpro_pkg::CMD_BUS_READ: lp_exp.push_back({1'b0, shadow[a[4:0]]});
            gpro_pkg::CMD_HP_READ: hp_exp.push_back(shadow[a[4:0]]);
            gpro_pkg::CMD_FLUSH: lp_exp.push_back({1'b1, 64'h0});
            gpro_pkg::CMD_FENCE: ;
            default: shadow[a[4:0]] = d;
        endcase
        if (cmd == gpro_pkg::CMD_HP_WRITE)
            hpw_exp.push_back(a);
    endtask
    task automatic drain(input string name);
        int i;
        req_valid <= 1'b0;
        for (i = 0; i < 3000; i++) begin
            @(posedge i_clock);
            if (hp_exp.size() == 0 && lp_exp.size() == 0 && hpw_exp.size() == 0)
                break;
        end
        if (i == 3000)
            timeout();
        $display("test %s done", name);
    endtask
    // ==========================================================
    // reply and write-issue monitor
    always @(negedge i_clock) begin
        if (rsp_valid === 1'b1 && rsp_hp === 1'b1) begin
            if (hp_exp.size() > 0)
                check(rsp_data, hp_exp.pop_front());
            else
                check(64'h1, 64'h0);
        end else if (rsp_valid === 1'b1) begin
            if (lp_exp.size() > 0) begin
                e = lp_exp.pop_front();
                check(64'(rsp_flush), 64'(e[64]));
                if (!e[64])
                    check(rsp_data, e[63:0]);
            end else
                check(64'h1, 64'h0);
        end
        if (mem_valid === 1'b1 && mem_ready === 1'b1 && mem_op === gpro_pkg::MEM_WRITE
            && mem_stream === gpro_pkg::STR_HP && hpw_exp.size() > 0)
            check(64'(mem_addr), 64'(hpw_exp.pop_front()));
    end
    // ==========================================================
    // main sequence
    initial begin
        int i, taken;
        logic [63:0] d;
        void'($urandom(32'hccb1));
        repeat (5) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        send(gpro_pkg::CMD_LP_WRITE, 32'h1, 64'h1111);
        send(gpro_pkg::CMD_LP_WRITE, 32'h1, 64'h2222);
        send(gpro_pkg::CMD_LP_READ, 32'h1, 64'h0);
        send(gpro_pkg::CMD_LP_READ, 32'h2, 64'h0);
        drain("lp_push");
        for (i = 0; i < 4; i++)
            send(gpro_pkg::CMD_LP_WRITE, 32'hc + 32'(i), {$urandom, $urandom});
        send(gpro_pkg::CMD_FLUSH, 32'h0, 64'h0);
        drain("preload");
        for (i = 0; i < 4; i++) begin
            send(gpro_pkg::CMD_HP_READ, 32'hc + 32'(i), 64'h0);
            send(gpro_pkg::CMD_HP_WRITE, 32'h8 + 32'(i), {$urandom, $urandom});
            send(gpro_pkg::CMD_LP_READ, 32'h1, 64'h0);
        end
        drain("hp_order");
        send(gpro_pkg::CMD_LP_READ, 32'h3, 64'h0);
        send(gpro_pkg::CMD_FENCE, 32'h0, 64'h0);
        send(gpro_pkg::CMD_LP_WRITE, 32'h3, 64'h3333);
        send(gpro_pkg::CMD_LP_READ, 32'h3, 64'h0);
        send(gpro_pkg::CMD_FLUSH, 32'h0, 64'h0);
        drain("fence");
        send(gpro_pkg::CMD_BUS_WRITE, 32'h10, 64'haaaa);
        send(gpro_pkg::CMD_BUS_READ, 32'h10, 64'h0);
        send(gpro_pkg::CMD_BUS_WRITE, 32'h10, 64'hbbbb);
        send(gpro_pkg::CMD_BUS_READ, 32'h10, 64'h0);
        drain("bus_order");
        hold <= 1'b1;
        req_valid <= 1'b1;
        req_cmd <= gpro_pkg::CMD_FLUSH;
        taken = 0;
        for (i = 0; i < 30; i++) begin
            @(negedge i_clock);
            if (req_ready === 1'b1) begin
                taken++;
                lp_exp.push_back({1'b1, 64'h0});
            end
            @(posedge i_clock);
        end
        check(64'(taken), 64'(DEPTH));
        @(negedge i_clock);
        check(64'(req_ready), 64'h0);
        @(posedge i_clock);
        req_cmd <= gpro_pkg::CMD_FENCE;
        @(negedge i_clock);
        check(64'(req_ready), 64'h1);
        @(posedge i_clock);
        hold <= 1'b0;
        drain("flush_fill");
        for (i = 0; i < 300; i++) begin
            d = {$urandom, $urandom};
            case ($urandom % 5)
                0: begin
                    send(gpro_pkg::CMD_FENCE, 32'h0, 64'h0);
                    send(gpro_pkg::CMD_LP_WRITE, 32'($urandom % 8), d);
                end
                1: send(gpro_pkg::CMD_LP_READ, 32'($urandom % 8), d);
                2: send(gpro_pkg::CMD_HP_WRITE, 32'h8 + 32'($urandom % 4), d);
                3: send(gpro_pkg::CMD_HP_READ, 32'hc + 32'($urandom % 4), d);
                default: send(gpro_pkg::CMD_FLUSH, 32'h0, d);
            endcase
        end
        drain("random");
        check(64'(hp_late), 64'h0);
        end_sim();
    end
endmodule
bind gpro_ordering gpro_ordering_sva #(.AW(AW)) u_gpro_ordering_sva (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
    .i_req_cmd(i_req_cmd), .o_req_ready(o_req_ready), .o_mem_valid(o_mem_valid),
    .o_mem_op(o_mem_op), .o_mem_stream(o_mem_stream), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .i_mem_ready(i_mem_ready), .i_mem_rvalid(i_mem_rvalid),
    .i_mem_rdata(i_mem_rdata), .i_mem_flush_done(i_mem_flush_done),
    .o_rsp_valid(o_rsp_valid), .o_rsp_high_priority_stream(o_rsp_high_priority_stream),
    .o_rsp_flush(o_rsp_flush), .o_rsp_data(o_rsp_data));
